// File: src/dcs_selector.sv
// drive control source selector with avalon-mm register slave
`timescale 1ns/1ps
`include "dcs_defs.svh"
// Notes on behaviour
// - code 0 runs only with both run contacts
// - configuration resets to code 0
// - code 1 is pressure control on input a
// - primary sensor failure swaps to backup sensor
// - code 2 select a picks target 1 or 2
// - code 3 select a,b pick targets 1..4
// - multi-target pressure modes need both run contacts
// - code 4 speed from current input a
// - code 5 speed from current input b
// - code 6 speed from voltage input
// - analog reference ignored at or below minimum speed level, except the code 10 level reference
// - codes 4,5,6 run only with both contacts
// - code 7 run contact a starts, stops
// - code 7 select a picks pressure or pot
// - code 7 pressure mode also needs contact b
// - code 8 select a forces backup sensor
// - precharge and lead/lag only in pressure modes
// - code 9 select a picks voltage or current
// - code 9 runs only with run contact a
// - code 10 pump-down from level transducer
module dcs_selector (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        run_contact_a,
    input  wire logic        run_contact_b,
    input  wire logic        select_contact_a,
    input  wire logic        select_contact_b,
    input  wire logic        sensor_a_fault,
    input  wire logic [7:0]  current_input_a,
    input  wire logic [7:0]  current_input_b,
    input  wire logic [7:0]  voltage_input,
    output logic             motor_run,
    output logic             hold_pressure_mode,
    output logic             use_backup_sensor,
    output logic [1:0]       pressure_target,
    output logic [2:0]       speed_source,
    output logic [7:0]       speed_reference,
    output logic             precharge_enable,
    output logic             lead_lag_enable,
    output logic             pump_down_mode
);
    typedef struct packed {
        logic [3:0]  cfg;
        logic [7:0]  minf;
        logic        fault_s1;
        logic        fault_s2;
        logic        failover;
        logic        ack;
        logic [31:0] rdata;
        logic        run;
        logic        hold;
        logic        backup;
        logic [1:0]  target;
        logic [2:0]  src;
        logic [7:0]  spd;
        logic        pumpdn;
        logic [7:0]  a_s1;
        logic [7:0]  a_s2;
        logic [7:0]  b_s1;
        logic [7:0]  b_s2;
        logic [7:0]  v_s1;
        logic [7:0]  v_s2;
    } dcs_state_t;

    dcs_state_t st_ff;
    dcs_state_t nxt_st;
    dcs_deb_if  deb ();

    logic ra;
    logic rb;
    logic sa;
    logic sb;

    assign deb.raw = {select_contact_b, select_contact_a, run_contact_b, run_contact_a};
    assign {sb, sa, rb, ra} = deb.clean;

    dcs_debounce u_deb (
        .clock (clock),
        .rst_n (rst_n),
        .dio   (deb.deb)
    );

    // level equivalent of the minimum frequency: full scale is 60 hz
    function automatic logic [7:0] gate_ref(input logic [7:0] v, input logic [7:0] minf);
        logic [15:0] thr;
        thr = 16'(minf) * 16'h00FF / 16'h003C;
        if (16'(v) > thr) begin
            gate_ref = v;
        end else begin
            gate_ref = 8'h00;
        end
    endfunction

    function automatic logic is_hold(input logic [3:0] c, input logic sel_a);
        is_hold = (c == 4'h1) || (c == 4'h2) || (c == 4'h3) || (c == 4'h8)
            || ((c == 4'h7) && !sel_a);
    endfunction

    logic both_run;
    logic hold_now;
    assign both_run = ra && rb;
    assign hold_now = is_hold(st_ff.cfg, sa);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.a_s1 = current_input_a;
        nxt_st.a_s2 = st_ff.a_s1;
        nxt_st.b_s1 = current_input_b;
        nxt_st.b_s2 = st_ff.b_s1;
        nxt_st.v_s1 = voltage_input;
        nxt_st.v_s2 = st_ff.v_s1;
        nxt_st.fault_s1 = sensor_a_fault;
        nxt_st.fault_s2 = st_ff.fault_s1;
        // failover latches until the configuration is rewritten
        if (st_ff.fault_s2) begin
            nxt_st.failover = 1'b1;
        end

        // single-cycle wait state, then the answer
        nxt_st.ack = (avs_read || avs_write) && !st_ff.ack;
        // a write lands only at the edge where the master sees waitrequest low
        if (avs_write && st_ff.ack) begin
            if (avs_address == `DCS_REG_CFG) begin
                if (avs_writedata[3:0] <= `DCS_CFG_MAX) begin
                    nxt_st.cfg = avs_writedata[3:0];
                end
                nxt_st.failover = st_ff.fault_s2;
            end else if (avs_address == `DCS_REG_MINF) begin
                if (avs_writedata[7:0] >= `DCS_MINF_FLOOR) begin
                    nxt_st.minf = avs_writedata[7:0];
                end
            end
        end
        if ((avs_read || avs_write) && !st_ff.ack) begin
            case (avs_address)
                `DCS_REG_CFG: nxt_st.rdata = {28'h0000000, st_ff.cfg};
                `DCS_REG_MINF: nxt_st.rdata = {24'h000000, st_ff.minf};
                `DCS_REG_STAT: nxt_st.rdata = {18'h00000, st_ff.failover, st_ff.pumpdn,
                    st_ff.src, st_ff.target, sb, sa, rb, ra, st_ff.backup, st_ff.hold,
                    st_ff.run};
                `DCS_REG_LVL: nxt_st.rdata = {st_ff.v_s2, st_ff.b_s2, st_ff.a_s2, st_ff.spd};
                default: nxt_st.rdata = 32'h00000000;
            endcase
        end

        nxt_st.run = 1'b0;
        nxt_st.hold = hold_now;
        nxt_st.backup = st_ff.failover;
        nxt_st.target = 2'h0;
        nxt_st.src = dcs_pkg::dcs_src_none;
        nxt_st.spd = 8'h00;
        nxt_st.pumpdn = 1'b0;
        case (st_ff.cfg)
            4'h0: begin
                nxt_st.run = both_run;
            end
            4'h1: begin
                nxt_st.run = both_run;
                nxt_st.src = dcs_pkg::dcs_src_pressure;
            end
            4'h2: begin
                nxt_st.run = both_run;
                nxt_st.src = dcs_pkg::dcs_src_pressure;
                nxt_st.target = {1'b0, sa};
            end
            4'h3: begin
                nxt_st.run = both_run;
                nxt_st.src = dcs_pkg::dcs_src_pressure;
                nxt_st.target = {sb, sa};
            end
            4'h4: begin
                nxt_st.run = both_run;
                nxt_st.src = dcs_pkg::dcs_src_cur_a;
                nxt_st.spd = gate_ref(st_ff.a_s2, st_ff.minf);
            end
            4'h5: begin
                nxt_st.run = both_run;
                nxt_st.src = dcs_pkg::dcs_src_cur_b;
                nxt_st.spd = gate_ref(st_ff.b_s2, st_ff.minf);
            end
            4'h6: begin
                nxt_st.run = both_run;
                nxt_st.src = dcs_pkg::dcs_src_volt;
                nxt_st.spd = gate_ref(st_ff.v_s2, st_ff.minf);
            end
            4'h7: begin
                if (sa) begin
                    nxt_st.run = ra;
                    nxt_st.src = dcs_pkg::dcs_src_volt;
                    nxt_st.spd = gate_ref(st_ff.v_s2, st_ff.minf);
                end else begin
                    nxt_st.run = ra && rb;
                    nxt_st.src = dcs_pkg::dcs_src_pressure;
                end
            end
            4'h8: begin
                nxt_st.run = both_run;
                nxt_st.src = dcs_pkg::dcs_src_pressure;
                nxt_st.backup = st_ff.failover || sa;
            end
            4'h9: begin
                nxt_st.run = ra;
                if (sa) begin
                    nxt_st.src = dcs_pkg::dcs_src_volt;
                    nxt_st.spd = gate_ref(st_ff.v_s2, st_ff.minf);
                end else begin
                    nxt_st.src = dcs_pkg::dcs_src_cur_a;
                    nxt_st.spd = gate_ref(st_ff.a_s2, st_ff.minf);
                end
            end
            4'hA: begin
                // level source: voltage unless only current input a is live
                nxt_st.run = both_run;
                nxt_st.pumpdn = 1'b1;
                nxt_st.src = dcs_pkg::dcs_src_level;
                nxt_st.spd = (st_ff.v_s2 != 8'h00) ? st_ff.v_s2 : st_ff.a_s2;
            end
            default: begin
                nxt_st.run = 1'b0;
            end
        endcase
        // backup only means something while pressure feedback is in use
        if (!hold_now) begin
            nxt_st.backup = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.cfg <= `DCS_CFG_RESET;
            st_ff.minf <= `DCS_MINF_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !st_ff.ack;
    assign avs_readdata = st_ff.rdata;
    assign motor_run = st_ff.run;
    assign hold_pressure_mode = st_ff.hold;
    assign use_backup_sensor = st_ff.backup;
    assign pressure_target = st_ff.target;
    assign speed_source = st_ff.src;
    assign speed_reference = st_ff.spd;
    assign precharge_enable = st_ff.hold;
    assign lead_lag_enable = st_ff.hold;
    assign pump_down_mode = st_ff.pumpdn;
endmodule

// File: include/dcs_defs.svh
// constants for the drive control source selector
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH
`define DCS_CFG_RESET       4'h0
`define DCS_CFG_MAX         4'hA
`define DCS_DEBOUNCE_US     1
`define DCS_CLK_MHZ         25
`define DCS_DEBOUNCE_CYC    (`DCS_DEBOUNCE_US * `DCS_CLK_MHZ)
`define DCS_MINF_RESET      8'h1E
`define DCS_MINF_FLOOR      8'h05
`define DCS_REG_CFG         4'h0
`define DCS_REG_MINF        4'h4
`define DCS_REG_STAT        4'h8
`define DCS_REG_LVL         4'hC
`define DCS_STAT_RUN        0
`define DCS_STAT_HOLD       1
`define DCS_STAT_BACKUP     2
`define DCS_STAT_AUX        3
`define DCS_STAT_SP_LO      4
`define DCS_STAT_SRC_LO     6
`define DCS_STAT_CON_LO     8
`endif

// File: include/dcs_pkg.sv
// types shared by the drive control source selector
package dcs_pkg;
    typedef enum logic [2:0] {
        dcs_src_none,
        dcs_src_pressure,
        dcs_src_cur_a,
        dcs_src_cur_b,
        dcs_src_volt,
        dcs_src_level
    } dcs_src_t;
endpackage

// File: include/dcs_deb_if.sv
// raw contact in, clean contact out, between top and debouncer
`timescale 1ns/1ps
interface dcs_deb_if;
    logic [3:0] raw;
    logic [3:0] clean;
    modport top (output raw, input clean);
    modport deb (input raw, output clean);
endinterface

// File: src/dcs_debounce.sv
// two-flop synchroniser and stability debouncer for four contacts
`timescale 1ns/1ps
`include "dcs_defs.svh"
module dcs_debounce (
    input  wire logic clock,
    input  wire logic rst_n,
    dcs_deb_if.deb    dio
);
    typedef struct packed {
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic [3:0]  clean;
        logic [3:0][7:0] cnt;
    } dcs_deb_state_t;

    dcs_deb_state_t st_ff;
    dcs_deb_state_t nxt_st;

    // a level must hold for the full count, so one bounce restarts it
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = dio.raw;
        nxt_st.s2 = st_ff.s1;
        for (int i = 0; i < 4; i++) begin
            if (st_ff.s2[i] == st_ff.clean[i]) begin
                nxt_st.cnt[i] = 8'h00;
            end else if (st_ff.cnt[i] == 8'(`DCS_DEBOUNCE_CYC - 1)) begin
                nxt_st.clean[i] = st_ff.s2[i];
                nxt_st.cnt[i] = 8'h00;
            end else begin
                nxt_st.cnt[i] = st_ff.cnt[i] + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dio.clean = st_ff.clean;
endmodule

// File: bench/dcs_field_model.sv
// field contacts that can chatter on command
`timescale 1ns/1ps
module dcs_field_model (
    input  wire logic       clock,
    input  wire logic [3:0] wanted,
    input  wire logic       chatter,
    output logic      [3:0] contacts
);
    logic [2:0] gl_ff = 3'h0;
    // a burst is four cycles, shorter than any sane debounce
    always_ff @(posedge clock) begin
        gl_ff <= chatter ? 3'h4 : (gl_ff != 3'h0 ? gl_ff - 3'h1 : 3'h0);
    end
    assign contacts = wanted ^ {4{gl_ff != 3'h0}};
endmodule

// File: bench/dcs_selector_asserts.sv
// port assertions for the selector
`timescale 1ns/1ps
module dcs_selector_asserts (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic        run_contact_a,
    input wire logic        motor_run,
    input wire logic        hold_pressure_mode,
    input wire logic [2:0]  speed_source,
    input wire logic        precharge_enable,
    input wire logic        lead_lag_enable,
    input wire logic        pump_down_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        avs_read || avs_write;
    endsequence
    sequence s_new_req;
        (avs_read || avs_write) && !$past(avs_read || avs_write);
    endsequence
    a_first_wait: assert property (s_new_req |-> avs_waitrequest)
        else $error("new request not stalled");
    a_one_wait: assert property ((s_req ##0 avs_waitrequest) |=> !avs_waitrequest)
        else $error("more than one wait state");
    a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait without request");
    a_data_stands: assert property (!(avs_read || avs_write) |=> $stable(avs_readdata))
        else $error("read data moved while idle");
    a_pre_lead: assert property (
        precharge_enable == hold_pressure_mode && lead_lag_enable == hold_pressure_mode)
        else $error("pump extras outside pressure mode");
    a_pump_src: assert property (
        pump_down_mode |-> speed_source == 3'h5 && !hold_pressure_mode)
        else $error("pump-down source wrong");
    a_hold_src: assert property (hold_pressure_mode |-> speed_source == 3'h1)
        else $error("pressure mode source wrong");
    // both samples sit well inside the stable window a clean start needs
    a_run_stable: assert property (
        $rose(motor_run) |-> $past(run_contact_a, 5) && $past(run_contact_a, 20))
        else $error("run started without stable contact");
endmodule
bind dcs_selector dcs_selector_asserts dcs_selector_asserts_i (.clock(clock), .rst_n(rst_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .run_contact_a(run_contact_a), .motor_run(motor_run),
    .hold_pressure_mode(hold_pressure_mode), .speed_source(speed_source),
    .precharge_enable(precharge_enable), .lead_lag_enable(lead_lag_enable),
    .pump_down_mode(pump_down_mode));

// File: bench/dcs_selector_tb.sv
// self-checking bench for the selector
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module dcs_selector_tb;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic        sensor_a_fault = 1'b0;
    logic        chatter = 1'b0;
    logic [3:0]  wanted = 4'h0;
    logic [7:0]  cur_a = 8'h0;
    logic [7:0]  cur_b = 8'h0;
    logic [7:0]  volt = 8'h0;
    logic [7:0]  seed = 8'h5D;
    logic [7:0]  thr;
    logic        fl = 1'b0;
    logic [31:0] obs;
    logic [63:0] ent;
    logic [63:0] q[$];
    int          n_errors = 0;
    int          num_checks = 0;
    event        got;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, motor_run, hold_pressure_mode, use_backup_sensor, pump_down_mode;
    wire [1:0] pressure_target;
    wire [2:0] speed_source;
    wire [7:0] speed_reference;
    wire [3:0] contacts;
    dcs_field_model dcs_field_model_i (.clock(clock), .wanted(wanted), .chatter(chatter),
        .contacts(contacts));
    dcs_selector dcs_selector_i (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .run_contact_a(contacts[0]), .run_contact_b(contacts[1]),
        .select_contact_a(contacts[2]), .select_contact_b(contacts[3]),
        .sensor_a_fault(sensor_a_fault), .current_input_a(cur_a), .current_input_b(cur_b),
        .voltage_input(volt), .motor_run(motor_run), .hold_pressure_mode(hold_pressure_mode),
        .use_backup_sensor(use_backup_sensor), .pressure_target(pressure_target),
        .speed_source(speed_source), .speed_reference(speed_reference),
        .precharge_enable(), .lead_lag_enable(), .pump_down_mode(pump_down_mode));
    initial forever #20 clock = ~clock;
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // mask in the high half, expected outputs in the low half
    function automatic logic [63:0] exp_out(input logic [3:0] cfg, input logic [3:0] c);
        logic hold;
        logic [2:0] src;
        logic [7:0] r;
        hold = cfg inside {4'h1, 4'h2, 4'h3, 4'h8} || (cfg == 4'h7 && !c[2]);
        src = hold ? 3'h1 : cfg == 4'h4 ? 3'h2 : cfg == 4'h5 ? 3'h3 :
            (cfg == 4'h6 || (cfg inside {4'h7, 4'h9} && c[2])) ? 3'h4 :
            cfg == 4'h9 ? 3'h2 : cfg == 4'hA ? 3'h5 : 3'h0;
        r = src == 3'h2 ? cur_a : src == 3'h3 ? cur_b : volt;
        r = r > thr ? r : 8'h0;
        // level source is ungated: voltage when live, else current input a
        if (src == 3'h5) begin
            r = volt != 8'h00 ? volt : cur_a;
        end
        return {16'h0, 5'h1F, {2{cfg inside {4'h2, 4'h3}}}, cfg inside {4'h1, 4'h2, 4'h3, 4'h8},
            {8{src inside {3'h2, 3'h3, 3'h4, 3'h5}}}, 16'h0,
            c[0] && (cfg == 4'h9 || (cfg == 4'h7 && c[2]) || c[1]), hold, src,
            cfg == 4'h3 ? c[3:2] : {1'b0, c[2]}, (cfg == 4'h8 && c[2]) || fl, r};
    endfunction
    task automatic note(input logic [63:0] e);
        q.push_back(e);
        -> got;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            finish_test();
        end
        obs = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        note({32'hFFFFFFFF, e});
    endtask
    task automatic settle(input logic [3:0] cfg, input int n = 40);
        repeat (n) @(posedge clock);
        obs = {16'h0, motor_run, hold_pressure_mode, speed_source, pressure_target,
            use_backup_sensor, speed_reference};
        note(exp_out(cfg, wanted));
    endtask
    initial forever begin
        @(got);
        ent = q.pop_front();
        `CHK(obs & ent[63:32], ent[31:0] & ent[63:32])
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h1E);
        rd(4'h1, 32'h0);
        bus(1'b1, 4'h0, 32'hB);
        bus(1'b1, 4'h4, 32'h4);
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h1E);
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, 4'h4, p ? 32'h5 : 32'h1E);
            thr = p ? 8'h15 : 8'h7F;
            for (int c = 0; c < 11; c++) begin
                bus(1'b1, 4'h0, 32'(c));
                for (int k = 0; k < 4; k++) begin
                    seed = lfsr_next(seed);
                    wanted <= k == 0 ? 4'hF : seed[3:0];
                    cur_a <= seed;
                    cur_b <= ~seed;
                    volt <= k == 1 ? thr : k == 2 ? thr + 8'h1 : {seed[3:0], seed[7:4]};
                    settle(4'(c));
                end
            end
        end
        $display("test modes done");
        bus(1'b1, 4'h0, 32'h2);
        sensor_a_fault <= 1'b1;
        fl = 1'b1;
        settle(4'h2);
        bus(1'b0, 4'h8, 32'h0);
        note({32'h00002000, 32'h00002000});
        sensor_a_fault <= 1'b0;
        settle(4'h2);
        bus(1'b1, 4'h0, 32'h2);
        fl = 1'b0;
        settle(4'h2);
        bus(1'b0, 4'h8, 32'h0);
        note({32'h00002000, 32'h00000000});
        rd(4'hC, {volt, cur_b, cur_a, 8'h00});
        $display("test failover done");
        bus(1'b1, 4'h0, 32'h0);
        wanted <= 4'hF;
        settle(4'h0);
        chatter <= 1'b1;
        @(posedge clock);
        chatter <= 1'b0;
        // look inside the burst too, where an undebounced path would drop run
        settle(4'h0, 6);
        settle(4'h0, 2);
        settle(4'h0);
        $display("test chatter done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h1E);
        $display("test reset done");
        #1;
        finish_test();
    end
endmodule
